// *** design/ubtx_pkg.sv ***
/*
  Shared constants of the serial port baud generator and transmit control block:
  register offsets, field positions, reset values, divider counts, bus responses.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package ubtx_pkg;
  localparam logic [7:0] A_TXCS = 8'h00;
  localparam logic [7:0] A_RXCS = 8'h04;
  localparam logic [7:0] A_DIV = 8'h08;
  localparam logic [7:0] A_DATA = 8'h0c;
  localparam logic [7:0] A_RXD = 8'h10;
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_HS = 2;
  localparam int TX_EMPTY = 1;
  localparam int TX_D9 = 0;
  localparam int RX_SERIAL_PORT_ENABLE = 7;
  localparam int RX_NINE = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam logic [7:0] TXCS_RST = 8'h02;
  localparam logic [7:0] TXCS_WMASK = 8'hf5;
  localparam logic [7:0] RXCS_RST = 8'h00;
  localparam logic [7:0] RXCS_WMASK = 8'hf0;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [1:0] PRE_ASYNC_LAST = 2'h3;
  localparam logic [1:0] PRE_SYNC_LAST = 2'h1;
  localparam logic [3:0] SUB_LO_LAST = 4'hf;
  localparam logic [3:0] SUB_HI_LAST = 4'h3;
  localparam logic [3:0] SMP_LO = 4'h7;
  localparam logic [3:0] SMP_HI = 4'h0;
  localparam logic [3:0] NB_ASYNC8 = 4'ha;
  localparam logic [3:0] NB_ASYNC9 = 4'hb;
  localparam logic [3:0] NB_SYNC8 = 4'h8;
  localparam logic [3:0] NB_SYNC9 = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;
endpackage

// *** design/ubtx_top.sv ***
/*
  Serial port baud generator, transmitter and receive sampler behind an
  AXI4-Lite slave, with a 32-word transmit FIFO.
  Assumes one 20 MHz clock and that the board resolves the TX/CK and RX/DT
  wires from the output enables.
*/
// The register offsets and register access over AXI4-Lite are this design's own decisions.
// How it works
// - The port runs asynchronous full duplex or synchronous half duplex as master or slave.
// - One dedicated 8-bit baud generator serves both modes.
// - The divisor register sets the period of a free-running 8-bit timer.
// - The high-speed bit changes the rate only in asynchronous mode.
// - The baud formulas apply only when the port makes its own clock.
// - Asynchronous low speed gives the clock divided by 64 times divisor plus one.
// - Asynchronous high speed gives the clock divided by 16 times divisor plus one.
// - Synchronous master gives the clock divided by 4 times divisor plus one.
// - The divisor is the unsigned 8-bit register value, 0 to 255.
// - Any divisor write with byte lane 0 strobed resets the generator timer at once.
// - The receiver samples each bit three times and takes the majority.
// - The divisor resets to zero on every reset.
`timescale 1ns/100ps
module ubtx_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp, rp, next_wp, next_rp;
  assign in_ready = (wp ^ rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp != rp;
  assign out_data = mem[rp[AW-1:0]];
  always_comb begin
    next_wp = (in_valid && in_ready) ? wp + 1'b1 : wp;
    next_rp = (out_valid && out_ready) ? rp + 1'b1 : rp;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
endmodule // ubtx_fifo

module ubtx_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic ck_in,
  output logic ck_out,
  output logic ck_oe,
  input wire logic dt_in,
  output logic dt_out,
  output logic dt_oe
);
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} ubtx_tx_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} ubtx_rx_e;
  localparam logic [3:0] NB8_STOP = 4'h9;
  localparam logic [3:0] NB9_STOP = 4'ha;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == ubtx_pkg::A_TXCS || a == ubtx_pkg::A_RXCS || a == ubtx_pkg::A_DIV
      || a == ubtx_pkg::A_DATA || a == ubtx_pkg::A_RXD;
  endfunction

  logic aw_got, w_got, next_aw_got, next_w_got, next_awready, next_wready;
  logic next_bvalid, next_arready, next_rvalid;
  logic [7:0] awa, next_awa;
  logic [31:0] wd, next_wd, next_rdata;
  logic [3:0] ws, next_ws;
  logic [1:0] next_bresp, next_rresp;
  logic [7:0] txcs, rxcs, div, next_txcs, next_rxcs, next_div;
  logic wr_do, wr_en, div_wr, f_in_valid, f_in_ready, f_out_valid, tx_go;
  logic [7:0] f_out_data;
  logic sync, clock_source_select, serial_port_enable, hs, nine, tick, tx_empty, transmit_enable_bit_eff;
  logic [1:0] pre, next_pre, pre_last;
  logic [7:0] baud_generator, next_brg;
  logic [3:0] sub_last, smp;
  ubtx_tx_e tx_st, next_tx_st;
  logic [10:0] sh, next_sh;
  logic [3:0] nb, next_nb, sub, next_sub;
  logic ck_lvl, next_ck_lvl, shift_ev, ck_s1, ck_s2, ck_s3, rx_s1, rx_s2;
  ubtx_rx_e rx_st, next_rx_st;
  logic [3:0] rsub, next_rsub, rbits, next_rbits;
  logic [2:0] samp, next_samp;
  logic [8:0] rsh, next_rsh;
  logic [7:0] rx_byte, next_rx_byte;
  logic rx_d9, next_rx_d9, rx_on, vote, rx_nine;
  logic next_ck_out, next_ck_oe, next_dt_out, next_dt_oe;

  assign sync = txcs[ubtx_pkg::TX_SYNC];
  assign clock_source_select = txcs[ubtx_pkg::TX_CLOCK_SOURCE_SELECT];
  assign hs = txcs[ubtx_pkg::TX_HS];
  assign nine = txcs[ubtx_pkg::TX_NINE];
  assign serial_port_enable = rxcs[ubtx_pkg::RX_SERIAL_PORT_ENABLE];
  assign tx_empty = tx_st == TX_IDLE;

  // Bus slave: address and data are held until both are present
  assign wr_do = aw_got && w_got && !s_axi_bvalid
    && (awa != ubtx_pkg::A_DATA || !ws[0] || f_in_ready);
  assign wr_en = wr_do && ws[0] && mapped(awa);
  assign div_wr = wr_en && awa == ubtx_pkg::A_DIV;
  assign f_in_valid = aw_got && w_got && !s_axi_bvalid && awa == ubtx_pkg::A_DATA && ws[0];
  always_comb begin
    next_aw_got = aw_got;
    next_awa = awa;
    next_w_got = w_got;
    next_wd = wd;
    next_ws = ws;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wd = s_axi_wdata;
      next_ws = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_do) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(awa) ? ubtx_pkg::RESP_OKAY : ubtx_pkg::RESP_SLVERR;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr) ? ubtx_pkg::RESP_OKAY : ubtx_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        ubtx_pkg::A_TXCS: next_rdata = {24'h0, txcs[7:2], tx_empty, txcs[0]};
        ubtx_pkg::A_RXCS: next_rdata = {24'h0, rxcs[7:4], 3'h0, rx_d9};
        ubtx_pkg::A_DIV: next_rdata = {24'h0, div};
        ubtx_pkg::A_RXD: next_rdata = {23'h0, rx_d9, rx_byte};
        default: next_rdata = 32'h0;
      endcase
    end
    next_arready = !next_rvalid;
    next_txcs = txcs;
    next_rxcs = rxcs;
    next_div = div;
    if (wr_en && awa == ubtx_pkg::A_TXCS) begin
      next_txcs = wd[7:0] & ubtx_pkg::TXCS_WMASK;
    end
    if (wr_en && awa == ubtx_pkg::A_RXCS) begin
      next_rxcs = wd[7:0] & ubtx_pkg::RXCS_WMASK;
    end
    if (div_wr) begin
      next_div = wd[7:0];
    end
  end

  // Baud generator: prescale then 8-bit reload timer, one tick per period
  assign pre_last = sync ? ubtx_pkg::PRE_SYNC_LAST : ubtx_pkg::PRE_ASYNC_LAST;
  assign tick = pre == pre_last && baud_generator == 8'h00 && !div_wr;
  always_comb begin
    next_pre = pre;
    next_brg = baud_generator;
    if (div_wr) begin
      next_pre = 2'h0;
      next_brg = wd[7:0];
    end else if (pre == pre_last) begin
      next_pre = 2'h0;
      next_brg = (baud_generator == 8'h00) ? div : baud_generator - 8'h01;
    end else begin
      next_pre = pre + 2'h1;
    end
  end

  // Ticks per bit: 16 at low speed, 4 at high speed, one half clock in sync
  assign sub_last = hs ? ubtx_pkg::SUB_HI_LAST : ubtx_pkg::SUB_LO_LAST;
  assign smp = hs ? ubtx_pkg::SMP_HI : ubtx_pkg::SMP_LO;
  // A receive enable steals the half-duplex line from the transmitter
  assign transmit_enable_bit_eff = txcs[ubtx_pkg::TX_EN]
    && !(sync && (rxcs[ubtx_pkg::RX_SINGLE_RECEIVE_ENABLE] || rxcs[ubtx_pkg::RX_CONTINUOUS_RECEIVE_ENABLE]));
  assign tx_go = tx_st == TX_IDLE && serial_port_enable && transmit_enable_bit_eff && f_out_valid;
  always_comb begin
    if (!sync) begin
      shift_ev = tick && sub == sub_last;
    end else if (clock_source_select) begin
      shift_ev = tick && ck_lvl;
    end else begin
      shift_ev = ck_s3 && !ck_s2;
    end
    next_tx_st = tx_st;
    next_sh = sh;
    next_nb = nb;
    next_sub = sub;
    next_ck_lvl = ck_lvl;
    unique case (tx_st)
      TX_IDLE: begin
        next_sub = 4'h0;
        next_ck_lvl = 1'b0;
        if (tx_go) begin
          next_tx_st = TX_SHIFT;
          if (sync) begin
            next_sh = {2'h3, txcs[ubtx_pkg::TX_D9], f_out_data};
            next_nb = nine ? ubtx_pkg::NB_SYNC9 : ubtx_pkg::NB_SYNC8;
          end else begin
            next_sh = {1'b1, nine ? txcs[ubtx_pkg::TX_D9] : 1'b1, f_out_data, 1'b0};
            next_nb = nine ? ubtx_pkg::NB_ASYNC9 : ubtx_pkg::NB_ASYNC8;
          end
        end
      end
      TX_SHIFT: begin
        if (!sync && tick) begin
          next_sub = (sub == sub_last) ? 4'h0 : sub + 4'h1;
        end
        if (sync && clock_source_select && tick) begin
          next_ck_lvl = !ck_lvl;
        end
        if (shift_ev) begin
          next_sh = {1'b1, sh[10:1]};
          next_nb = nb - 4'h1;
          if (nb == 4'h1) begin
            next_tx_st = TX_IDLE;
          end
        end
      end
    endcase
  end

  // Receiver: three samples around mid-bit, majority decides
  assign rx_on = serial_port_enable && rxcs[ubtx_pkg::RX_CONTINUOUS_RECEIVE_ENABLE] && !sync;
  assign rx_nine = rxcs[ubtx_pkg::RX_NINE];
  assign vote = (samp[0] && samp[1]) || (samp[0] && samp[2]) || (samp[1] && samp[2]);
  always_comb begin
    next_rx_st = rx_st;
    next_rsub = rsub;
    next_rbits = rbits;
    next_samp = samp;
    next_rsh = rsh;
    next_rx_byte = rx_byte;
    next_rx_d9 = rx_d9;
    unique case (rx_st)
      RX_IDLE: begin
        next_rsub = 4'h0;
        next_rbits = 4'h0;
        if (rx_on && !rx_s2) begin
          next_rx_st = RX_BUSY;
        end
      end
      RX_BUSY: begin
        if (!rx_on) begin
          next_rx_st = RX_IDLE;
        end else if (tick) begin
          next_rsub = (rsub == sub_last) ? 4'h0 : rsub + 4'h1;
          if (rsub >= smp && rsub <= smp + 4'h2) begin
            next_samp = {samp[1:0], rx_s2};
          end
          if (rsub == sub_last) begin
            next_rbits = rbits + 4'h1;
            if (rbits == 4'h0 && vote) begin
              next_rx_st = RX_IDLE;
            end else if (rbits == (rx_nine ? NB9_STOP : NB8_STOP)) begin
              next_rx_byte = rx_nine ? rsh[7:0] : rsh[8:1];
              next_rx_d9 = rx_nine && rsh[8];
              next_rx_st = RX_IDLE;
            end else if (rbits != 4'h0) begin
              next_rsh = {vote, rsh[8:1]};
            end
          end
        end
      end
    endcase
    next_ck_out = sync ? ck_lvl : (tx_st == TX_IDLE || sh[0]);
    next_ck_oe = serial_port_enable && (!sync || clock_source_select);
    next_dt_out = tx_st == TX_IDLE || sh[0];
    next_dt_oe = serial_port_enable && sync && tx_st == TX_SHIFT;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awa <= 8'h00;
      wd <= 32'h0;
      ws <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ubtx_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= ubtx_pkg::RESP_OKAY;
      txcs <= ubtx_pkg::TXCS_RST;
      rxcs <= ubtx_pkg::RXCS_RST;
      div <= ubtx_pkg::DIV_RST;
      pre <= 2'h0;
      baud_generator <= 8'h00;
      tx_st <= TX_IDLE;
      sh <= 11'h7ff;
      nb <= 4'h0;
      sub <= 4'h0;
      ck_lvl <= 1'b0;
      {ck_s1, ck_s2, ck_s3, rx_s1, rx_s2} <= 5'h1f;
      rx_st <= RX_IDLE;
      rsub <= 4'h0;
      rbits <= 4'h0;
      samp <= 3'h7;
      rsh <= 9'h0;
      rx_byte <= 8'h00;
      rx_d9 <= 1'b0;
      {ck_out, ck_oe, dt_out, dt_oe} <= 4'ha;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awa <= next_awa;
      wd <= next_wd;
      ws <= next_ws;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      txcs <= next_txcs;
      rxcs <= next_rxcs;
      div <= next_div;
      pre <= next_pre;
      baud_generator <= next_brg;
      tx_st <= next_tx_st;
      sh <= next_sh;
      nb <= next_nb;
      sub <= next_sub;
      ck_lvl <= next_ck_lvl;
      {ck_s1, ck_s2, ck_s3, rx_s1, rx_s2} <= {ck_in, ck_s1, ck_s2, dt_in, rx_s1};
      rx_st <= next_rx_st;
      rsub <= next_rsub;
      rbits <= next_rbits;
      samp <= next_samp;
      rsh <= next_rsh;
      rx_byte <= next_rx_byte;
      rx_d9 <= next_rx_d9;
      {ck_out, ck_oe, dt_out, dt_oe} <= {next_ck_out, next_ck_oe, next_dt_out, next_dt_oe};
    end
  end

  ubtx_fifo #(.W(ubtx_pkg::FIFO_W), .D(ubtx_pkg::FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(wd[7:0]),
    .out_valid(f_out_valid),
    .out_ready(tx_go),
    .out_data(f_out_data)
  );

  // Cycles between ticks, valid once a full period ran without a rate change
  logic [10:0] gap;
  logic gap_ok;
  always_ff @(posedge clk_sys) begin
    if (srst || div_wr || sync != $past(sync)) begin
      gap <= 11'h0;
      gap_ok <= 1'b0;
    end else begin
      gap <= tick ? 11'h0 : gap + 11'h1;
      gap_ok <= gap_ok || tick;
    end
  end

  property p_rate;
    @(posedge clk_sys) disable iff (srst)
      tick && gap_ok && !$past(div_wr) |->
        gap == ({3'h0, div} + 11'h1) * (sync ? 11'h2 : 11'h4) - 11'h1;
  endproperty
  a_rate: assert property (p_rate) else $error("tick spacing wrong");
  property p_divwr;
    @(posedge clk_sys) disable iff (srst)
      div_wr |=> baud_generator == $past(wd[7:0]) && pre == 2'h0 && !tick;
  endproperty
  a_divwr: assert property (p_divwr) else $error("divisor write did not reset timer");
  property p_divrst;
    @(posedge clk_sys) $past(srst) && !srst |-> div == 8'h00;
  endproperty
  a_divrst: assert property (p_divrst) else $error("divisor not zero after reset");
  property p_empty;
    @(posedge clk_sys) disable iff (srst)
      tx_go |=> !tx_empty;
  endproperty
  a_empty: assert property (p_empty) else $error("empty flag not cleared on start");
  property p_sub;
    @(posedge clk_sys) disable iff (srst) !sync && tx_st == TX_SHIFT |-> sub <= sub_last;
  endproperty
  a_sub: assert property (p_sub) else $error("bit sub-count beyond speed limit");
  property p_vote;
    @(posedge clk_sys) disable iff (srst)
      rx_st == RX_BUSY && rx_on && tick && rsub == sub_last && rbits == 4'h0 && vote
        |=> rx_st == RX_IDLE;
  endproperty
  a_vote: assert property (p_vote) else $error("false start not rejected");
  property p_slave;
    @(posedge clk_sys) disable iff (srst) sync && !clock_source_select |=> !ck_oe;
  endproperty
  a_slave: assert property (p_slave) else $error("slave drives clock pin");
  property p_frame;
    @(posedge clk_sys) disable iff (srst)
      tx_go && !sync |=> nb == ($past(nine) ? ubtx_pkg::NB_ASYNC9 : ubtx_pkg::NB_ASYNC8);
  endproperty
  a_frame: assert property (p_frame) else $error("frame length wrong");
  property p_async_pin;
    @(posedge clk_sys) disable iff (srst) !sync |=> ck_oe == $past(serial_port_enable) && !dt_oe;
  endproperty
  a_async_pin: assert property (p_async_pin) else $error("async pin enables wrong");
endmodule // ubtx_top

// *** testbench/ubtx_term.sv ***
/*
  Behavioural serial terminal on the far side of the port: it receives
  asynchronous frames, measures one data bit, and sends frames back.
  Assumes the bench resolves both wires and sets the bit length in clocks.
*/
`timescale 1ns/100ps
module ubtx_term (
  input wire logic clk_sys,
  input wire logic line_in,
  input wire logic nine,
  input wire logic [15:0] bit_clks,
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic glitch,
  output logic line_out,
  output logic tx_busy,
  output logic [8:0] got_byte,
  output logic got_stop,
  output logic [7:0] got_count,
  output logic [15:0] meas
);
  logic [8:0] shreg;
  logic [9:0] frame;
  int i;
  int j;
  int c;
  int k;
  initial begin
    line_out = 1'b1;
    tx_busy = 1'b0;
    got_byte = 9'h000;
    got_stop = 1'b0;
    got_count = 8'h00;
    meas = 16'h0000;
  end
  // Samples mid-bit from the start edge; tolerates a start bit cut short by one tick
  always begin : rx_p
    @(posedge clk_sys);
    if (line_in === 1'b0) begin
      repeat (bit_clks / 2) @(posedge clk_sys);
      shreg = 9'h000;
      for (i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (bit_clks) @(posedge clk_sys);
        shreg[i] = line_in;
      end
      repeat (bit_clks) @(posedge clk_sys);
      got_stop <= line_in;
      got_byte <= shreg;
      got_count <= got_count + 8'h01;
    end
  end
  // Length of the first high run after the start bit; exact only when bit 0 is 1, bit 1 is 0
  always begin : meas_p
    @(posedge clk_sys);
    if (line_in === 1'b0) begin
      k = 0;
      while (line_in !== 1'b1) @(posedge clk_sys);
      while (line_in === 1'b1) begin
        k++;
        @(posedge clk_sys);
      end
      meas <= k[15:0];
      @(got_count);
    end
  end
  // Optional one-clock inverted spike mid-bit, too short to win a three-sample vote
  always begin : tx_p
    @(posedge clk_sys);
    if (send === 1'b1) begin
      tx_busy <= 1'b1;
      frame = {1'b1, send_byte, 1'b0};
      for (j = 0; j < 10; j++) begin
        for (c = 0; c < bit_clks; c++) begin
          line_out <= (glitch === 1'b1 && c == bit_clks / 2) ? ~frame[j] : frame[j];
          @(posedge clk_sys);
        end
      end
      line_out <= 1'b1;
      tx_busy <= 1'b0;
    end
  end
endmodule // ubtx_term

// *** testbench/usart_baud_generator_tx_control_test.sv ***
/*
  Register-level test of the baud generator and transmit control block.
  Assumes a pull-up on TX/CK and that the terminal model drives RX/DT when the port does not.
*/
`timescale 1ns/100ps
module usart_baud_generator_tx_control_test;
  logic clk_sys;
  logic srst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata, rd_data;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic ck_out, ck_oe, dt_out, dt_oe, term_line, tx_busy, got_stop;
  logic nine = 1'b0, send = 1'b0, glitch = 1'b0;
  logic [15:0] bit_clks = 16'h0040, meas;
  logic [7:0] send_byte = 8'h00, got_count, base;
  logic [8:0] got_byte;
  logic [7:0] tab_x [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
  logic tab_hs [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  int fails = 0;
  int n_checks = 0;
  logic ck_ext = 1'b1;
  wire ck_wire = ck_oe ? ck_out : ck_ext;
  wire dt_wire = dt_oe ? dt_out : term_line;

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ubtx_top dut (.clk_sys(clk_sys), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .ck_in(ck_wire), .ck_out(ck_out),
    .ck_oe(ck_oe), .dt_in(dt_wire), .dt_out(dt_out), .dt_oe(dt_oe));

  ubtx_term term (.clk_sys(clk_sys), .line_in(ck_wire), .nine(nine), .bit_clks(bit_clks),
    .send(send), .send_byte(send_byte), .glitch(glitch), .line_out(term_line),
    .tx_busy(tx_busy), .got_byte(got_byte), .got_stop(got_stop), .got_count(got_count),
    .meas(meas));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_left;
    logic w_left;
    int t;
    aw_left = 1'b1;
    w_left = 1'b1;
    t = 0;
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    // A full FIFO holds the response back, so the wait is long but bounded
    while (t < 60000) begin
      @(posedge clk_sys);
      t++;
      if (aw_left && s_axi_awready === 1'b1) begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1) begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (t >= 60000) fails++;
  endtask

  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    while (t < 1000) begin
      @(posedge clk_sys);
      t++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (t >= 1000) fails++;
  endtask

  task automatic wait_line(input logic lvl);
    int t;
    t = 0;
    while (ck_wire !== lvl && t < 60000) begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 60000) fails++;
  endtask

  task automatic wait_count(input logic [7:0] target);
    int t;
    t = 0;
    while (got_count !== target && t < 60000) begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 60000) fails++;
  endtask

  task automatic wait_empty;
    int t;
    t = 0;
    rd(ubtx_pkg::A_TXCS);
    while (rd_data[ubtx_pkg::TX_EMPTY] !== 1'b1 && t < 20000) begin
      rd(ubtx_pkg::A_TXCS);
      t++;
    end
    if (t >= 20000) fails++;
  endtask

  initial begin : watchdog
    repeat (90000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end

  initial begin : main
    logic [15:0] exp;
    logic [7:0] b;
    int hi;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    rd(ubtx_pkg::A_TXCS);
    chk(rd_data, {24'h0, ubtx_pkg::TXCS_RST});
    rd(ubtx_pkg::A_RXCS);
    chk(rd_data, {24'h0, ubtx_pkg::RXCS_RST});
    rd(ubtx_pkg::A_DIV);
    chk(rd_data, {24'h0, ubtx_pkg::DIV_RST});
    rd(8'h14);
    chk({30'h0, resp}, {30'h0, ubtx_pkg::RESP_SLVERR});
    chk(rd_data, 32'h0);
    wr(8'h14, 32'h0000_00ff, 4'h1);
    chk({30'h0, resp}, {30'h0, ubtx_pkg::RESP_SLVERR});
    wr(ubtx_pkg::A_DIV, 32'h0000_00ab, 4'h0);
    rd(ubtx_pkg::A_DIV);
    chk(rd_data, 32'h0000_0000);
    wr(ubtx_pkg::A_TXCS, 32'h0000_0000, 4'h1);
    rd(ubtx_pkg::A_TXCS);
    chk(rd_data, 32'h0000_0002);
    wr(ubtx_pkg::A_RXCS, 32'h0000_0080, 4'h1);
    // Both speeds: divisors 0 and 1 at low speed, 2 and 255 at high speed
    for (int i = 0; i < 4; i++) begin
      wr(ubtx_pkg::A_TXCS, tab_hs[i] ? 32'h0000_0024 : 32'h0000_0020, 4'h1);
      wr(ubtx_pkg::A_DIV, {24'h0, tab_x[i]}, 4'h1);
      exp = (tab_hs[i] ? 16'h0010 : 16'h0040) * ({8'h00, tab_x[i]} + 16'h0001);
      bit_clks <= exp;
      base = got_count;
      wr(ubtx_pkg::A_DATA, 32'h0000_0055, 4'h1);
      wait_line(1'b0);
      rd(ubtx_pkg::A_TXCS);
      chk({31'h0, rd_data[ubtx_pkg::TX_EMPTY]}, 32'h0);
      wait_count(base + 8'h01);
      chk({16'h0, meas}, {16'h0, exp});
      chk({22'h0, got_stop, got_byte}, 32'h0000_0255);
      wait_empty();
    end
    wr(ubtx_pkg::A_TXCS, 32'h0000_0065, 4'h1);
    wr(ubtx_pkg::A_DIV, 32'h0000_0000, 4'h1);
    bit_clks <= 16'h0010;
    nine <= 1'b1;
    base = got_count;
    wr(ubtx_pkg::A_DATA, 32'h0000_00c3, 4'h1);
    wait_count(base + 8'h01);
    chk({23'h0, got_byte}, 32'h0000_01c3);
    wait_empty();
    nine <= 1'b0;
    wr(ubtx_pkg::A_TXCS, 32'h0000_0024, 4'h1);
    base = got_count;
    // Pushes outrun the line, so the FIFO fills and stalls the write response
    fork
      for (int p = 0; p < 34; p++) wr(ubtx_pkg::A_DATA, {24'h0, 8'h10 + p[7:0]}, 4'h1);
      for (int q = 0; q < 34; q++) begin
        wait_count(base + q[7:0] + 8'h01);
        chk({23'h0, got_byte}, {24'h0, 8'h10 + q[7:0]});
      end
    join
    wait_empty();
    wr(ubtx_pkg::A_RXCS, 32'h0000_0090, 4'h1);
    wr(ubtx_pkg::A_TXCS, 32'h0000_0020, 4'h1);
    wr(ubtx_pkg::A_DIV, 32'h0000_0001, 4'h1);
    bit_clks <= 16'h0080;
    glitch <= 1'b1;
    send_byte <= 8'h96;
    base = got_count;
    wr(ubtx_pkg::A_DATA, 32'h0000_0055, 4'h1);
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    @(posedge clk_sys);
    wait_count(base + 8'h01);
    chk({23'h0, got_byte}, 32'h0000_0055);
    hi = 0;
    while (tx_busy === 1'b1 && hi < 5000) begin
      hi++;
      @(posedge clk_sys);
    end
    // The receiver closes its frame a few clocks after the sender drops busy
    repeat (32) @(posedge clk_sys);
    rd(ubtx_pkg::A_RXD);
    chk(rd_data, 32'h0000_0096);
    // A start bit far shorter than half a bit votes high and is dropped
    glitch <= 1'b0;
    bit_clks <= 16'h0010;
    send_byte <= 8'hff;
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    repeat (300) @(posedge clk_sys);
    rd(ubtx_pkg::A_RXD);
    chk(rd_data, 32'h0000_0096);
    wr(ubtx_pkg::A_RXCS, 32'h0000_0080, 4'h1);
    wr(ubtx_pkg::A_DIV, 32'h0000_0003, 4'h1);
    wr(ubtx_pkg::A_TXCS, 32'h0000_00b4, 4'h1);
    wait_line(1'b0);
    wr(ubtx_pkg::A_DATA, 32'h0000_003c, 4'h1);
    exp = 16'h0002 * (16'h0003 + 16'h0001);
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      wait_line(1'b1);
      b[i] = dt_out;
      if (i == 0) chk({30'h0, ck_oe, dt_oe}, 32'h0000_0003);
      hi = 0;
      while (ck_wire === 1'b1 && hi < 1000) begin
        hi++;
        @(posedge clk_sys);
      end
      chk(hi, {16'h0, exp});
    end
    chk({24'h0, b}, 32'h0000_003c);
    wait_empty();
    wr(ubtx_pkg::A_TXCS, 32'h0000_0030, 4'h1);
    rd(ubtx_pkg::A_TXCS);
    chk({rd_data[30:0], ck_oe}, 32'h0000_0064);
    wr(ubtx_pkg::A_DATA, 32'h0000_00a5, 4'h1);
    for (int i = 0; i < 8; i++) begin
      repeat (6) @(posedge clk_sys);
      b[i] = dt_out;
      ck_ext <= 1'b0;
      repeat (6) @(posedge clk_sys);
      ck_ext <= 1'b1;
    end
    chk({24'h0, b}, 32'h0000_00a5);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(ubtx_pkg::A_DIV);
    chk(rd_data, 32'h0000_0000);
    print_verdict();
  end
endmodule // usart_baud_generator_tx_control_test
